// ### verilog/cpm_top.sv
// general-purpose counter: edge count, pulse, period, semi-period
//
// The register offsets and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
`include "cpm_params.svh"
module cpm_top #(
    parameter int CW = `CPM_COUNT_W,
    parameter int AW = `CPM_ADDR_W
) (
    input  wire logic          clk,
    input  wire logic          resetn,
    input  wire logic [AW-1:0] address,
    input  wire logic          read,
    input  wire logic          write,
    input  wire logic [31:0]   writedata,
    output logic [31:0]        readdata,
    output logic               waitrequest,
    input  wire logic          gate,
    input  wire logic          source,
    input  wire logic          updown,
    output logic [CW-1:0]      capture_data,
    output logic               capture_valid
);
    logic [`CPM_CTRL_W-1:0] ctrl_ff;
    logic                   done_ff;
    logic [CW-1:0]          count_ff;
    logic [CW-1:0]          save_ff;
    logic [31:0]            rdata_ff;
    logic [CW-1:0]          cap_data_ff;
    logic                   cap_valid_ff;
    logic                   wait_ff;
    logic                   src_last_ff;
    cpm_pkg::state_t        state_ff;
    cpm_pkg::state_t        nxt_state;

    logic acc_ff;
    logic acc_wr;
    logic gate_lvl;
    logic gate_rise;
    logic gate_fall;
    logic dir_lvl;
    logic src_edge;
    logic gate_act;
    logic lead_edge;
    logic trail_edge;
    logic any_edge;
    logic arm_cmd;
    logic disarm_cmd;
    logic latch;
    logic restart;
    logic [CW-1:0] nxt_count;

    cpm_pkg::mode_t mode;
    cpm_pkg::dir_t  dir;
    logic           src_fall;
    logic           gate_low;
    logic           buffered;

    function automatic logic [31:0] widen(input logic [CW-1:0] v);
        widen = 32'(v);
    endfunction

    // write strobe aimed at one register offset
    function automatic logic hit(input logic          wr,
                                 input logic [AW-1:0] a,
                                 input logic [AW-1:0] off);
        hit = wr && a == off;
    endfunction

    cpm_avalon #(.AW(AW)) u_bus (
        .clk         (clk),
        .resetn      (resetn),
        .address     (address),
        .read        (read),
        .write       (write),
        .waitrequest (),
        .acc_ff      (acc_ff),
        .acc_rd      (),
        .acc_wr      (acc_wr)
    );

    cpm_sync u_gate (
        .clk    (clk),
        .resetn (resetn),
        .din    (gate),
        .level  (gate_lvl),
        .rise   (gate_rise),
        .fall   (gate_fall)
    );

    cpm_sync u_dir (
        .clk    (clk),
        .resetn (resetn),
        .din    (updown),
        .level  (dir_lvl),
        .rise   (),
        .fall   ()
    );

    assign mode     = cpm_pkg::mode_t'(
                      ctrl_ff[`CPM_CTRL_MODE_MSB:`CPM_CTRL_MODE_LSB]);
    assign dir      = cpm_pkg::dir_t'(
                      ctrl_ff[`CPM_CTRL_DIR_MSB:`CPM_CTRL_DIR_LSB]);
    assign src_fall = ctrl_ff[`CPM_CTRL_SRC_FALL];
    assign gate_low = ctrl_ff[`CPM_CTRL_GATE_LOW];
    assign buffered = ctrl_ff[`CPM_CTRL_BUFFERED];

    assign src_edge = src_fall ? (src_last_ff & ~source)
                               : (~src_last_ff & source);

    assign gate_act   = gate_low ? ~gate_lvl : gate_lvl;
    assign lead_edge  = gate_low ? gate_fall : gate_rise;
    assign trail_edge = gate_low ? gate_rise : gate_fall;
    assign any_edge   = gate_rise | gate_fall;

    assign arm_cmd    = hit(acc_wr, address, `CPM_OFF_CMD)
                        && writedata[`CPM_CMD_ARM];
    assign disarm_cmd = hit(acc_wr, address, `CPM_OFF_CMD)
                        && writedata[`CPM_CMD_DISARM];

    // latch condition per mode while running
    always_comb begin
        latch   = 1'b0;
        restart = 1'b0;
        if (state_ff == cpm_pkg::ST_RUN) begin
            case (mode)
                cpm_pkg::MODE_PULSE, cpm_pkg::MODE_SEMI: begin
                    if (mode == cpm_pkg::MODE_SEMI && buffered) begin
                        latch   = any_edge;
                        restart = any_edge;
                    end else begin
                        latch = trail_edge;
                    end
                end
                cpm_pkg::MODE_PERIOD: begin
                    latch   = lead_edge;
                    restart = lead_edge;
                end
                default: begin
                    latch   = 1'b0;
                    restart = 1'b0;
                end
            endcase
        end
    end

    // state sequencing
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            cpm_pkg::ST_IDLE: begin
                if (arm_cmd) begin
                    if (mode == cpm_pkg::MODE_EDGE) begin
                        nxt_state = cpm_pkg::ST_RUN;
                    end else if (buffered && mode != cpm_pkg::MODE_PULSE) begin
                        nxt_state = cpm_pkg::ST_RUN;
                    end else begin
                        nxt_state = cpm_pkg::ST_WAIT;
                    end
                end
            end
            cpm_pkg::ST_WAIT: begin
                // start only on entry to active
                if (lead_edge) begin
                    nxt_state = cpm_pkg::ST_RUN;
                end
            end
            cpm_pkg::ST_RUN: begin
                if (latch && !buffered) begin
                    nxt_state = cpm_pkg::ST_DONE;
                end else if (latch && mode == cpm_pkg::MODE_PULSE) begin
                    nxt_state = cpm_pkg::ST_WAIT;
                end
            end
            cpm_pkg::ST_DONE: begin
                if (arm_cmd) begin
                    nxt_state = cpm_pkg::ST_IDLE;
                end
            end
            default: nxt_state = cpm_pkg::ST_IDLE;
        endcase
        if (disarm_cmd) begin
            nxt_state = cpm_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= cpm_pkg::ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            src_last_ff <= 1'b0;
        end else begin
            src_last_ff <= source;
        end
    end

    // counter next value
    always_comb begin
        nxt_count = count_ff;
        if (state_ff == cpm_pkg::ST_IDLE && arm_cmd) begin
            nxt_count = '0;
        end else if (state_ff == cpm_pkg::ST_WAIT) begin
            nxt_count = '0;
        end else if (state_ff == cpm_pkg::ST_RUN) begin
            if (mode == cpm_pkg::MODE_EDGE) begin
                if (src_edge) begin
                    if (dir == cpm_pkg::DIR_DOWN
                        || (dir == cpm_pkg::DIR_PIN && !dir_lvl)) begin
                        nxt_count = count_ff - 1'b1;
                    end else begin
                        nxt_count = count_ff + 1'b1;
                    end
                end
            end else if (restart) begin
                nxt_count = CW'(src_edge);
            end else if (src_edge
                         && (mode != cpm_pkg::MODE_PULSE || gate_act)) begin
                nxt_count = count_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_ff <= '0;
        end else begin
            count_ff <= nxt_count;
        end
    end

    // save register holds until next latch
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            save_ff <= '0;
        end else if (latch) begin
            save_ff <= count_ff;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cap_valid_ff <= 1'b0;
            cap_data_ff  <= '0;
        end else begin
            cap_valid_ff <= latch;
            if (latch) begin
                cap_data_ff <= count_ff;
            end
        end
    end

    // done flag: set wins over clear by arm
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            done_ff <= 1'b0;
        end else if (latch && !buffered) begin
            done_ff <= 1'b1;
        end else if (arm_cmd || disarm_cmd) begin
            done_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_ff <= `CPM_CTRL_RESET;
        end else if (hit(acc_wr, address, `CPM_OFF_CTRL)
                     && state_ff == cpm_pkg::ST_IDLE) begin
            ctrl_ff <= writedata[`CPM_CTRL_W-1:0];
        end
    end

    // read mux, registered
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_ff <= '0;
        end else if (read && !acc_ff) begin
            if (address == `CPM_OFF_CTRL) begin
                rdata_ff <= 32'(ctrl_ff);
            end else if (address == `CPM_OFF_STATUS) begin
                rdata_ff <= {29'h0, state_ff == cpm_pkg::ST_RUN, done_ff,
                             state_ff != cpm_pkg::ST_IDLE
                             && state_ff != cpm_pkg::ST_DONE};
            end else if (address == `CPM_OFF_COUNT) begin
                rdata_ff <= (mode == cpm_pkg::MODE_EDGE)
                            ? widen(count_ff) : widen(save_ff);
            end else begin
                rdata_ff <= `CPM_UNMAPPED_DATA;
            end
        end
    end

    // stall flag kept in a flop so the pin is registered
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wait_ff <= 1'b1;
        end else begin
            wait_ff <= ~((read | write) & ~acc_ff);
        end
    end

    assign readdata      = rdata_ff;
    assign waitrequest   = wait_ff;
    assign capture_data  = cap_data_ff;
    assign capture_valid = cap_valid_ff;
endmodule

// ### verilog/cpm_params.svh
// constants for the pulse and period measuring counter
`ifndef CPM_PARAMS_SVH
`define CPM_PARAMS_SVH

`define CPM_COUNT_W      32
// register byte offsets
`define CPM_OFF_CTRL     4'h0
`define CPM_OFF_CMD      4'h4
`define CPM_OFF_STATUS   4'h8
`define CPM_OFF_COUNT    4'hc
`define CPM_ADDR_W       4
// control field positions
`define CPM_CTRL_MODE_LSB  0
`define CPM_CTRL_MODE_MSB  2
`define CPM_CTRL_DIR_LSB   4
`define CPM_CTRL_DIR_MSB   5
`define CPM_CTRL_SRC_FALL  8
`define CPM_CTRL_GATE_LOW  9
`define CPM_CTRL_BUFFERED  10
`define CPM_CTRL_W         11
`define CPM_CTRL_RESET     11'h000
// command bits
`define CPM_CMD_ARM        0
`define CPM_CMD_DISARM     1
// status bit positions
`define CPM_ST_ARMED       0
`define CPM_ST_DONE        1
`define CPM_ST_RUNNING     2
// bus answer for unmapped addresses
`define CPM_UNMAPPED_DATA  32'h0000_0000

`endif

// ### verilog/cpm_pkg.sv
// types for the pulse and period measuring counter
package cpm_pkg;

    typedef enum logic [2:0] {
        MODE_EDGE   = 3'h0,
        MODE_PULSE  = 3'h1,
        MODE_PERIOD = 3'h2,
        MODE_SEMI   = 3'h3
    } mode_t;

    typedef enum logic [1:0] {
        DIR_UP   = 2'h0,
        DIR_DOWN = 2'h1,
        DIR_PIN  = 2'h2
    } dir_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_WAIT = 4'b0010,
        ST_RUN  = 4'b0100,
        ST_DONE = 4'b1000
    } state_t;

endpackage

// ### verilog/cpm_sync.sv
// two-flop synchroniser with edge detect behind the second flop
`timescale 1ns/1ps
module cpm_sync (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic din,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta_ff;
    logic sync_ff;
    logic last_ff;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            last_ff <= 1'b0;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    assign level = sync_ff;
    assign rise  = sync_ff & ~last_ff;
    assign fall  = ~sync_ff & last_ff;
endmodule

// ### verilog/cpm_avalon.sv
// avalon-mm slave: one wait state on every access
`timescale 1ns/1ps
`include "cpm_params.svh"
module cpm_avalon #(
    parameter int AW = `CPM_ADDR_W
) (
    input  wire logic          clk,
    input  wire logic          resetn,
    input  wire logic [AW-1:0] address,
    input  wire logic          read,
    input  wire logic          write,
    output logic               waitrequest,
    output logic               acc_ff,
    output logic               acc_rd,
    output logic               acc_wr
);
    // first cycle of a request stalls, second completes
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            acc_ff <= 1'b0;
        end else begin
            acc_ff <= (read | write) & ~acc_ff;
        end
    end

    assign waitrequest = ~acc_ff;
    assign acc_rd      = acc_ff & read;
    assign acc_wr      = acc_ff & write;
endmodule

// ### verification/cpm_top_assertions.sv
// port assertions for the measuring counter
`timescale 1ns/1ps
module cpm_top_chk #(
    parameter int CW = 32,
    parameter int AW = 4
) (
    input wire logic          clk,
    input wire logic          resetn,
    input wire logic [AW-1:0] address,
    input wire logic          read,
    input wire logic          write,
    input wire logic [31:0]   readdata,
    input wire logic          waitrequest,
    input wire logic          gate,
    input wire logic [CW-1:0] capture_data,
    input wire logic          capture_valid
);
    logic [7:0] gch_ff;
    logic       gq_ff;
    // history of gate changes at the pin
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            gch_ff <= 8'h00;
            gq_ff  <= 1'b0;
        end else begin
            gq_ff  <= gate;
            gch_ff <= {gch_ff[6:0], gate ^ gq_ff};
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_valid_one_cycle: assert property (
        capture_valid |=> !capture_valid) else $error("valid too long");
    a_capture_after_gate: assert property (
        capture_valid |-> |gch_ff[7:1]) else $error("capture without gate");
    a_data_holds: assert property (
        capture_valid |=> $stable(capture_data) [*3])
        else $error("capture data moved");
    a_wait_answer: assert property (
        (read || write) && waitrequest |=> !waitrequest)
        else $error("no bus answer");
    a_wait_recover: assert property (
        !waitrequest |=> waitrequest) else $error("wait low too long");
    a_wait_needs_req: assert property (
        $fell(waitrequest) |-> $past(read || write))
        else $error("answer without request");
    a_unmapped_zero: assert property (
        !waitrequest && read && address[1:0] != 2'b00 |-> readdata == 32'h0)
        else $error("unmapped read not zero");
    a_rdata_on_read: assert property (
        $changed(readdata) |-> $past(read)) else $error("readdata moved");
endmodule

bind cpm_top cpm_top_chk #(.CW(CW), .AW(AW)) u_chk (
    .clk(clk), .resetn(resetn), .address(address), .read(read),
    .write(write), .readdata(readdata), .waitrequest(waitrequest),
    .gate(gate), .capture_data(capture_data),
    .capture_valid(capture_valid));

// ### verification/cpm_src_model.sv
// source timebase and gate pulse model
`timescale 1ns/1ps
module cpm_src_model (
    input  wire logic  clk,
    output logic       gate,
    output logic       source,
    output logic [3:0] phase
);
    initial begin
        gate  = 1'b0;
        phase = 4'h0;
    end
    // known timebase, 16 clocks a period
    assign source = ~phase[3];
    always @(posedge clk) begin
        phase <= phase + 4'h1;
    end
    // gate levels last whole source periods
    task automatic hold(input logic lvl, input int per);
        @(posedge clk iff phase == 4'h1);
        gate <= lvl;
        repeat (16 * per - 1) @(posedge clk);
    endtask
endmodule

// ### verification/counter_pulse_period_measure_tb_top.sv
// self-checking bench for the measuring counter
`timescale 1ns/1ps
module counter_pulse_period_measure_tb_top;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic [3:0]  address = 4'h0;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        gate;
    logic        source;
    logic        updown = 1'b0;
    logic [31:0] capture_data;
    logic        capture_valid;
    logic [3:0]  phase;
    logic [31:0] exp_q[$];
    logic [31:0] rq;
    logic [31:0] q0;
    logic [31:0] e;
    integer      seed = 32'hb5dc;
    int          err_count = 0;
    int          n_tests = 0;
    int          cyc = 0;
    int          h;
    int          l;
    always #10 clk = ~clk;
    cpm_top dut (.clk(clk), .resetn(resetn), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .gate(gate),
        .source(source), .updown(updown), .capture_data(capture_data),
        .capture_valid(capture_valid));
    cpm_src_model m (.clk(clk), .gate(gate), .source(source),
        .phase(phase));
    task automatic give_verdict;
        $display("tests=%0d errors=%0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic int rn();
        return 1 + int'($random(seed) & 32'h3);
    endfunction
    task automatic bus(input logic wr_en, input logic [3:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        address   <= a;
        writedata <= d;
        read      <= ~wr_en;
        write     <= wr_en;
        do
            @(posedge clk);
        while (waitrequest !== 1'b0);
        rq = readdata;
        read  <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rq, exp);
    endtask
    task automatic cfg(input logic [31:0] c);
        bus(1'b1, 4'h4, 32'h2);
        bus(1'b1, 4'h0, c);
        bus(1'b1, 4'h4, 32'h1);
    endtask
    task automatic settle;
        repeat (12) @(posedge clk);
        chk(32'(exp_q.size()), 32'h0);
        bus(1'b1, 4'h4, 32'h2);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (capture_valid === 1'b1) begin
            e = exp_q.size() != 0 ? exp_q.pop_front() : 32'hx;
            if (e !== 32'hffff_ffff)
                chk(capture_data, e);
        end
        if (cyc == 20000) begin
            err_count++;
            give_verdict();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        rd(4'h8, 32'h0);
        bus(1'b1, 4'h2, 32'hffff_ffff);
        rd(4'h2, 32'h0);
        rd(4'h0, 32'h0);
        for (int i = 1; i < 4; i += 2) begin
            m.hold(1'b1, 1);
            cfg(32'(i));
            rd(4'h8, 32'h1);
            m.hold(1'b0, 1);
            h = rn();
            exp_q.push_back(32'(h));
            m.hold(1'b1, h);
            m.hold(1'b0, 2);
            m.hold(1'b1, 1);
            m.hold(1'b0, 1);
            rd(4'hc, 32'(h));
            rd(4'h8, 32'h2);
            settle();
        end
        m.hold(1'b1, 1);
        cfg(32'h701);
        rd(4'h0, 32'h701);
        for (int i = 0; i < 3; i++) begin
            h = rn();
            exp_q.push_back(32'(h));
            m.hold(1'b0, h);
            m.hold(1'b1, rn());
        end
        settle();
        for (int p = 0; p < 2; p++) begin
            m.hold(p[0], 1);
            cfg(32'h2 | (32'(p) << 9));
            h = rn();
            l = rn();
            exp_q.push_back(32'(h + l));
            m.hold(~p[0], h);
            m.hold(p[0], l);
            m.hold(~p[0], 1);
            m.hold(p[0], 1);
            m.hold(~p[0], 1);
            settle();
        end
        for (int md = 2; md < 4; md++) begin
            m.hold(1'b0, 1);
            cfg(32'h400 | 32'(md));
            exp_q.push_back(32'hffff_ffff);
            for (int i = 0; i < 3; i++) begin
                h = rn();
                l = rn();
                if (md == 2)
                    exp_q.push_back(32'(h + l));
                else begin
                    exp_q.push_back(32'(h));
                    exp_q.push_back(32'(l));
                end
                m.hold(1'b1, h);
                m.hold(1'b0, l);
            end
            m.hold(1'b1, 1);
            settle();
        end
        for (int i = 0; i < 4; i++) begin
            updown <= (i == 2);
            cfg(32'((i > 2 ? 2 : i) << 4));
            rd(4'h8, 32'h5);
            h = rn();
            @(posedge clk iff phase == 4'h5);
            bus(1'b0, 4'hc, 32'h0);
            q0 = rq;
            repeat (16 * h - 8) @(posedge clk);
            @(posedge clk iff phase == 4'h5);
            bus(1'b0, 4'hc, 32'h0);
            chk(rq - q0, i % 2 ? -32'(h) : 32'(h));
        end
        give_verdict();
    end
endmodule
